//--- hw/ddp_pkg.sv
// Purpose: shared constants and types of the dual protocol debug port
// Assumes: debug pins are sampled by the system clock
// Notes:   counts are in debug clock edges; BAD_LIMIT counts bad data phases
package ddp_pkg;
    localparam logic [3:0] IR_ABORT   = 4'h8;
    localparam logic [3:0] IR_DP_ACC  = 4'ha;
    localparam logic [3:0] IR_AP_ACC  = 4'hb;
    localparam logic [3:0] IR_IDENT   = 4'he;
    localparam logic [3:0] IR_BYPASS  = 4'hf;
    localparam logic [3:0] IR_CAPT    = 4'h1;
    localparam int         ACC_LEN    = 35;
    localparam int         IDENT_LEN  = 32;
    localparam int         BYP_LEN    = 1;
    localparam int         DR_W       = 35;
    localparam int         WORD_W     = 32;
    localparam logic [2:0] SC_OK      = 3'h2;
    localparam logic [2:0] SC_WAIT    = 3'h1;
    localparam logic [2:0] SW_OK      = 3'h1;
    localparam logic [2:0] SW_WAIT    = 3'h2;
    localparam logic [5:0] HDR_LAST   = 6'h06;
    localparam logic [5:0] ACK_LAST   = 6'h02;
    localparam logic [5:0] DATA_LAST  = 6'h20;
    localparam logic [5:0] LINE_RESET = 6'h32;
    localparam logic [2:0] TMS_RESET  = 3'h5;
    localparam logic [1:0] BAD_LIMIT  = 2'h2;
    localparam int         SYNC_W     = 4;
    localparam int         PIN_CLK    = 0;
    localparam int         PIN_DIO    = 1;
    localparam int         PIN_TDI    = 2;
    localparam int         PIN_RSTN   = 3;
    localparam logic [3:0] SYNC_RST   = 4'h8;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
        TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } ddp_tap_e;

    typedef enum logic [2:0] {
        SW_IDLE, SW_HDR, SW_TRN, SW_ACK, SW_RD, SW_WR, SW_LOCK
    } ddp_sw_e;

    typedef struct packed {
        logic              abort;
        logic              ap;
        logic              rnw;
        logic [1:0]        addr;
        logic [WORD_W-1:0] data;
    } ddp_req_s;

    localparam int REQ_W = $bits(ddp_req_s);
endpackage

//--- hw/ddp_fifo.sv
// Purpose: request queue between the debug engines and the access side
// Assumes: DEPTH is a power of two
// Notes:   first word is visible at the output while out_valid_o is high
`timescale 1ns/10ps
`default_nettype none
module ddp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_sys_i,
    input  wire logic         resetn_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
        logic                    vld;
        logic                    rdy;
        logic [W-1:0]            head;
    } ddp_fifo_s;

    ddp_fifo_s q;
    ddp_fifo_s d;
    logic      push;
    logic      pop;

    always_comb begin
        d    = q;
        push = in_valid_i && (q.cnt != FULL);
        pop  = out_ready_i && (q.cnt != '0);
        if (push) begin
            d.mem[q.wr] = in_data_i;
            d.wr        = q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = q.rd + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // flags and head follow the next state so the outputs leave straight from flops
        d.vld  = (d.cnt != '0);
        d.rdy  = (d.cnt != FULL);
        d.head = d.mem[d.rd];
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            q     <= '0;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign in_ready_o  = q.rdy;
    assign out_valid_o = q.vld;
    assign out_data_o  = q.head;
endmodule
`default_nettype wire

//--- hw/ddp_debug_port.sv
// Purpose: scan-chain and two-wire views of an external debug port
// Assumes: debug clock far slower than clk_sys_i (8x or more)
// Notes:   protocol selection comes from serial_mode_i, not a watcher
`timescale 1ns/10ps
`default_nettype none
// Operation
// - instruction 1000 selects 35-bit abort register
// - 1010 and 1011 select 35-bit access registers
// - 1110 selects 32-bit identification register
// - 1111 and unlisted codes give bypass bit
// - five clocks with mode high reset state
// - no returned clock goes back to host
// - capture loads value, update launches access
// - serial transfer is request, acknowledge, data
// - crossing from debug clock is synchronised
// - stopped idle clock keeps state, resumes later
// - only host originates headers and timing
// - line handled on supplied clock edges only
// - drive high, low or release; survive contention
// - release line for turnaround between drivers
// - fifty high clocks then identification read resync
// - two bad data phases lock until reset
// - lost sync releases line, waits header
module ddp_debug_port
    import ddp_pkg::*;
#(
    parameter logic [31:0] ID_CODE    = 32'h0000_0001, // arbitrary value
    parameter int          FIFO_DEPTH = 8
) (
    input  wire logic              clk_sys_i,
    input  wire logic              resetn_i,
    input  wire logic              serial_mode_i,
    input  wire logic              shared_debug_clock_i,
    input  wire logic              shared_data_mode_line_i,
    output logic                   shared_data_mode_line_o,
    output logic                   shared_data_mode_line_oe_o,
    input  wire logic              scan_data_input_i,
    output logic                   scan_data_output_o,
    input  wire logic              scan_reset_low_i,
    output logic                   acc_req_valid_o,
    input  wire logic              acc_req_ready_i,
    output ddp_req_s               acc_req_o,
    input  wire logic              acc_rdata_valid_i,
    input  wire logic [WORD_W-1:0] acc_rdata_i,
    output logic                   lockout_o
);
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] filt;
        ddp_tap_e          tap;
        logic [3:0]        ir;
        logic [3:0]        ir_sr;
        logic [DR_W-1:0]   dr;
        logic              tdo;
        logic [2:0]        tms_cnt;
        ddp_sw_e           sw;
        logic [5:0]        cnt;
        logic [7:0]        hdr;
        logic [WORD_W:0]   sh;
        logic [2:0]        ack;
        logic              ok;
        logic [1:0]        bad;
        logic [5:0]        hi;
        logic              dio;
        logic              dio_oe;
        logic              push;
        ddp_req_s          req;
        logic [WORD_W-1:0] rdata;
        logic              lock;
    } ddp_state_s;

    ddp_state_s       q;
    ddp_state_s       d;
    logic             rise;
    logic             fall;
    logic             tms;
    logic             tdi;
    logic             dio;
    logic             rstn_f;
    logic             fifo_ready;
    logic [REQ_W-1:0] fifo_out;
    logic [SYNC_W-1:0] agree;
    logic [7:0]       h;
    logic [WORD_W:0]  w;
    logic [WORD_W-1:0] word;

    function automatic ddp_tap_e tap_next(input ddp_tap_e s, input logic m);
        unique case (s)
            TAP_RESET:  tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction

    function automatic logic is_acc(input logic [3:0] ir);
        is_acc = (ir == IR_DP_ACC) || (ir == IR_AP_ACC);
    endfunction

    // top bit of the selected data path; shift-in lands here
    function automatic int dr_msb(input logic [3:0] ir);
        if (is_acc(ir) || ir == IR_ABORT) begin
            dr_msb = ACC_LEN - 1;
        end else if (ir == IR_IDENT) begin
            dr_msb = IDENT_LEN - 1;
        end else begin
            dr_msb = BYP_LEN - 1;
        end
    endfunction

    always_comb begin
        d      = q;
        // three-stage synchroniser, value moves once stages two and three agree
        d.s1   = {scan_reset_low_i, scan_data_input_i, shared_data_mode_line_i, shared_debug_clock_i};
        d.s2   = q.s1;
        d.s3   = q.s2;
        agree  = ~(q.s2 ^ q.s3);
        d.filt = (q.filt & ~agree) | (q.s2 & agree);
        rise   = d.filt[PIN_CLK] && !q.filt[PIN_CLK];
        fall   = !d.filt[PIN_CLK] && q.filt[PIN_CLK];
        tms    = d.filt[PIN_DIO];
        dio    = d.filt[PIN_DIO];
        tdi    = d.filt[PIN_TDI];
        rstn_f = d.filt[PIN_RSTN];
        h      = {dio, q.hdr[7:1]};
        w      = {dio, q.sh[WORD_W:1]};
        word   = q.rdata;
        d.push = 1'b0;
        if (acc_rdata_valid_i) begin
            d.rdata = acc_rdata_i;
        end

        // nothing below moves without a debug clock edge, except scan reset and the serial-state clear in scan view
        if (!serial_mode_i) begin
            d.dio_oe = 1'b0;
            d.sw     = SW_IDLE;
            d.hi     = '0;
            if (!rstn_f) begin
                d.tap     = TAP_RESET;
                d.ir      = IR_IDENT;
                d.tms_cnt = '0;
            end else if (rise) begin
                unique case (q.tap)
                    TAP_RESET: begin
                        d.ir = IR_IDENT;
                    end
                    TAP_CAP_DR: begin
                        if (is_acc(q.ir)) begin
                            d.dr = {q.rdata, fifo_ready ? SC_OK : SC_WAIT};
                        end else if (q.ir == IR_IDENT) begin
                            d.dr = {3'h0, ID_CODE};
                        end else begin
                            d.dr = '0;
                        end
                    end
                    TAP_SH_DR: begin
                        d.dr             = q.dr >> 1;
                        d.dr[dr_msb(q.ir)] = tdi;
                    end
                    TAP_UPD_DR: begin
                        // full queue drops the update; the host saw WAIT at an access capture, zero at an abort capture
                        if ((is_acc(q.ir) || q.ir == IR_ABORT) && fifo_ready) begin
                            d.push       = 1'b1;
                            d.req.abort  = (q.ir == IR_ABORT);
                            d.req.ap     = (q.ir == IR_AP_ACC);
                            d.req.rnw    = q.dr[0];
                            d.req.addr   = q.dr[2:1];
                            d.req.data   = q.dr[DR_W-1:3];
                        end
                    end
                    TAP_CAP_IR: begin
                        d.ir_sr = IR_CAPT;
                    end
                    TAP_SH_IR: begin
                        d.ir_sr = {tdi, q.ir_sr[3:1]};
                    end
                    TAP_UPD_IR: begin
                        d.ir = q.ir_sr;
                    end
                    default: begin
                    end
                endcase
                d.tap     = tap_next(q.tap, tms);
                d.tms_cnt = !tms ? 3'h0 : (q.tms_cnt == TMS_RESET) ? q.tms_cnt : q.tms_cnt + 3'h1;
            end
            // data out changes on the falling edge; no clock is ever returned
            if (fall) begin
                if (q.tap == TAP_SH_DR) begin
                    d.tdo = q.dr[0];
                end else if (q.tap == TAP_SH_IR) begin
                    d.tdo = q.ir_sr[0];
                end
            end
        end else if (rise) begin
            d.tms_cnt = '0;
            // own drive must not count toward a line reset
            d.hi = (dio && !q.dio_oe) ? ((q.hi == LINE_RESET) ? q.hi : q.hi + 6'h1) : 6'h0;
            unique case (q.sw)
                SW_IDLE: begin
                    if (dio) begin
                        d.sw  = SW_HDR;
                        d.hdr = h;
                        d.cnt = '0;
                    end
                end
                SW_HDR: begin
                    d.hdr = h;
                    d.cnt = q.cnt + 6'h1;
                    if (q.cnt == HDR_LAST) begin
                        // h[1] port kind, h[2] read, h[4:3] address
                        if (!(^h[5:1]) && !h[6] && h[7]) begin
                            d.sw = SW_TRN;
                        end else begin
                            d.sw     = SW_IDLE;
                            d.dio_oe = 1'b0;
                        end
                    end
                end
                SW_TRN: begin
                    d.ok     = fifo_ready;
                    d.ack    = fifo_ready ? SW_OK : SW_WAIT;
                    d.dio    = fifo_ready ? SW_OK[0] : SW_WAIT[0];
                    d.dio_oe = 1'b1;
                    d.sw     = SW_ACK;
                    d.cnt    = '0;
                    // identity of port address zero answers at once, others are posted
                    if (!q.hdr[1] && q.hdr[4:3] == 2'h0) begin
                        word = ID_CODE;
                    end
                    d.sh = {^word, word};
                    if (fifo_ready && q.hdr[2]) begin
                        d.push     = 1'b1;
                        d.req      = '0;
                        d.req.ap   = q.hdr[1];
                        d.req.rnw  = 1'b1;
                        d.req.addr = q.hdr[4:3];
                    end
                end
                SW_ACK: begin
                    d.cnt = q.cnt + 6'h1;
                    if (q.cnt != ACK_LAST) begin
                        d.ack = q.ack >> 1;
                        d.dio = q.ack[1];
                    end else if (!q.ok) begin
                        d.sw     = SW_IDLE;
                        d.dio_oe = 1'b0;
                    end else if (q.hdr[2]) begin
                        d.sw  = SW_RD;
                        d.dio = q.sh[0];
                        d.sh  = q.sh >> 1;
                        d.cnt = '0;
                    end else begin
                        d.sw     = SW_WR;
                        d.dio_oe = 1'b0;
                        d.cnt    = '0;
                    end
                end
                SW_RD: begin
                    d.cnt = q.cnt + 6'h1;
                    if (q.cnt == DATA_LAST) begin
                        d.sw     = SW_IDLE;
                        d.dio_oe = 1'b0;
                    end else begin
                        d.dio = q.sh[0];
                        d.sh  = q.sh >> 1;
                    end
                end
                SW_WR: begin
                    d.sh  = w;
                    d.cnt = q.cnt + 6'h1;
                    if (q.cnt == DATA_LAST) begin
                        d.sw = SW_IDLE;
                        if (!(^w)) begin
                            d.push     = 1'b1;
                            d.req      = '0;
                            d.req.ap   = q.hdr[1];
                            d.req.addr = q.hdr[4:3];
                            d.req.data = w[WORD_W-1:0];
                            d.bad      = '0;
                        end else begin
                            d.bad = q.bad + 2'h1;
                            if (q.bad + 2'h1 == BAD_LIMIT) begin
                                d.sw = SW_LOCK;
                            end
                        end
                    end
                end
                SW_LOCK: begin
                end
                default: begin
                    d.sw = SW_IDLE;
                end
            endcase
            if (d.hi == LINE_RESET) begin
                d.sw     = SW_IDLE;
                d.bad    = '0;
                d.dio_oe = 1'b0;
            end
        end
        d.lock = (d.sw == SW_LOCK);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            q      <= '0;
            q.s1   <= SYNC_RST;
            q.s2   <= SYNC_RST;
            q.s3   <= SYNC_RST;
            q.filt <= SYNC_RST;
            q.ir   <= IR_IDENT;
        end else begin
            q <= d;
        end
    end

    ddp_fifo #(
        .W     (REQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (q.push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (q.req),
        .out_valid_o (acc_req_valid_o),
        .out_ready_i (acc_req_ready_i),
        .out_data_o  (fifo_out)
    );

    assign acc_req_o                  = fifo_out;
    assign scan_data_output_o         = q.tdo;
    assign shared_data_mode_line_o    = q.dio;
    assign shared_data_mode_line_oe_o = q.dio_oe;
    assign lockout_o                  = q.lock;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_tdo_on_fall: assert property ($changed(q.tdo) |-> $past(fall))
        else $error("scan data out moved off a falling edge");
    a_abort_launch: assert property (rise && !serial_mode_i && rstn_f && q.tap == TAP_UPD_DR
        && q.ir == IR_ABORT && fifo_ready |=> q.push && q.req.abort)
        else $error("abort update launched nothing");
    a_acc_launch: assert property (rise && !serial_mode_i && rstn_f && q.tap == TAP_UPD_DR
        && is_acc(q.ir) && fifo_ready |=> q.push && q.req.ap == $past(q.ir[0]))
        else $error("access update launched wrong request");
    a_ident_capture: assert property (rise && !serial_mode_i && rstn_f && q.tap == TAP_CAP_DR
        && q.ir == IR_IDENT |=> q.dr == {3'h0, ID_CODE})
        else $error("identity capture wrong");
    a_bypass_shift: assert property (rise && !serial_mode_i && rstn_f && q.tap == TAP_SH_DR
        && q.ir == IR_BYPASS && q.dr == '0 |=> q.dr == {34'h0, $past(tdi)})
        else $error("bypass path is not one bit");
    a_tms_reset: assert property (q.tms_cnt == TMS_RESET |-> q.tap == TAP_RESET)
        else $error("five mode-high clocks did not reset");
    a_trn_release: assert property (q.sw == SW_TRN || q.sw == SW_WR |-> !q.dio_oe)
        else $error("line driven in turnaround or write");
    a_lock_silent: assert property (q.sw == SW_LOCK |-> !q.dio_oe ##1 !q.dio_oe)
        else $error("locked port drove the line");
    a_line_reset: assert property (q.hi == LINE_RESET |-> q.sw == SW_IDLE && q.bad == 2'h0)
        else $error("line reset did not clear the port");
    a_oe_on_edge: assert property ($changed(q.dio_oe) |-> $past(rise) || $past(!serial_mode_i))
        else $error("line drive changed off a clock edge");
    a_sync_lost: assert property (rise && serial_mode_i && q.sw == SW_HDR && q.cnt == HDR_LAST
        && q.hdr[7] |=> q.sw == SW_IDLE && !q.dio_oe)
        else $error("bad stop bit not handled");

    c_scan_push: cover property (q.push && !serial_mode_i);
    c_sw_read: cover property (q.sw == SW_RD);
    c_sw_write: cover property (q.push && serial_mode_i && !q.req.rnw);
    c_sw_lock: cover property (q.sw == SW_LOCK);
endmodule
`default_nettype wire

//--- verification/ddp_host_model.sv
// Purpose: host probe model driving the debug clock, line and scan data
// Assumes: one debug bit spans 8 system clocks, 400 ns
// Notes:   clock stands low between bits; released line reads the pullup
`timescale 1ns/10ps
`default_nettype none
module ddp_host_model (
    input  wire logic clk_sys_i,
    input  wire logic line_i,
    input  wire logic tdo_i,
    output logic      tck_o,
    output logic      d_o,
    output logic      oe_o,
    output logic      tdi_o
);
    initial begin
        tck_o = 1'b0;
        d_o   = 1'b0;
        oe_o  = 1'b1;
        tdi_o = 1'b0;
    end
    // data moves on the fall, line read just before the rise
    task automatic step(input logic d, input logic oe, input logic tdi, output logic ts, output logic ls);
        d_o   <= d;
        oe_o  <= oe;
        tdi_o <= tdi;
        repeat (4) @(posedge clk_sys_i);
        ls = line_i;
        tck_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        ts = tdo_i;
        tck_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verification/ddp_debug_port_tb_top.sv
// Purpose: self-checking bench of the debug port, scan then serial view
// Assumes: host model steps one debug bit per 8 system clocks
// Notes:   queue is held full once to see the wait answer
`timescale 1ns/10ps
`default_nettype none
module ddp_debug_port_tb_top;
    import ddp_pkg::*;
    localparam logic [31:0] ID = 32'h0000_0001; // arbitrary value
    logic              clk_sys_i = 1'b0;
    logic              resetn_i  = 1'b0;
    logic              smode     = 1'b0;
    logic              rdy       = 1'b0;
    logic              rv        = 1'b0;
    logic              trst_n    = 1'b1;
    logic [WORD_W-1:0] rd        = 32'h1234abcd;
    logic              tck, hd, hoe, tdi, dev_o, dev_oe, tdo, vld, lock;
    ddp_req_s          req;
    int                err_total = 0;
    int                cmp_count = 0;
    // pullup wins when nobody drives
    wire line = dev_oe ? dev_o : (hoe ? hd : 1'b1);
    always #25 clk_sys_i = ~clk_sys_i;
    ddp_debug_port #(.ID_CODE(ID), .FIFO_DEPTH(8)) ddp_debug_port_inst (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .serial_mode_i(smode),
        .shared_debug_clock_i(tck), .shared_data_mode_line_i(line), .shared_data_mode_line_o(dev_o),
        .shared_data_mode_line_oe_o(dev_oe), .scan_data_input_i(tdi), .scan_data_output_o(tdo),
        .scan_reset_low_i(trst_n), .acc_req_valid_o(vld), .acc_req_ready_i(rdy), .acc_req_o(req),
        .acc_rdata_valid_i(rv), .acc_rdata_i(rd), .lockout_o(lock));
    ddp_host_model ddp_host_model_inst (.clk_sys_i(clk_sys_i), .line_i(line), .tdo_i(tdo),
        .tck_o(tck), .d_o(hd), .oe_o(hoe), .tdi_o(tdi));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tbit(input logic m, input logic t, output logic o);
        logic l;
        ddp_host_model_inst.step(m, 1'b1, t, o, l);
    endtask
    task automatic hold(input int n, input logic d);
        logic t, l;
        repeat (n) ddp_host_model_inst.step(d, 1'b1, 1'b0, t, l);
    endtask
    // from idle: capture, shift n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [39:0] din, output logic [39:0] dout);
        logic o;
        dout = '0;
        tbit(1'b1, 1'b0, o);
        if (ir) tbit(1'b1, 1'b0, o);
        tbit(1'b0, 1'b0, o);
        tbit(1'b0, 1'b0, o);
        for (int k = 0; k < n; k++) tbit(k == n - 1, din[k], dout[k]);
        tbit(1'b1, 1'b0, o);
        tbit(1'b0, 1'b0, o);
    endtask
    function automatic logic [39:0] exp_dr(input logic [3:0] c, input logic [2:0] ack);
        case (c)
            4'h8: return {5'h1f, 35'h0};
            4'ha, 4'hb: return {5'h1f, rd, ack};
            4'he: return {8'hff, ID};
            default: return 40'hff_ffff_fffe;
        endcase
    endfunction
    task automatic pop(input ddp_req_s e, input logic f);
        for (int w = 0; w < 200 && vld !== 1'b1; w++) @(posedge clk_sys_i);
        check(f ? 40'(req) : 40'({req.abort, req.data}), f ? 40'(e) : 40'({e.abort, e.data}));
        rdy <= 1'b1;
        @(posedge clk_sys_i);
        rdy <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // header, turnaround, ack, 33 data bits, then 9 idle-low edges
    task automatic sw(input logic [7:0] h, input logic wr, input logic [32:0] wd,
                      output logic [2:0] ack, output logic [32:0] r);
        logic t, l;
        for (int k = 0; k < 8; k++) ddp_host_model_inst.step(h[k], 1'b1, 1'b0, t, l);
        ddp_host_model_inst.step(1'b0, 1'b0, 1'b0, t, l);
        // device drives ack right after the turnaround rise; a further released rise
        // would show the pullup and be taken as a start bit
        for (int j = 0; j < 36; j++) begin
            ddp_host_model_inst.step(wd[j < 3 ? 0 : j - 3], wr && j >= 3, 1'b0, t, l);
            if (j <= 2) ack[j] = l;
            if (j >= 3) r[j-3] = l;
        end
        hold(9, 1'b0);
    endtask
    initial begin
        logic [39:0] o;
        logic [2:0]  a;
        logic [32:0] r;
        logic [3:0]  c;
        logic [31:0] w;
        w = 32'hcafe0001;
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        rv <= 1'b1;
        @(posedge clk_sys_i);
        rv <= 1'b0;
        tbit(1'b0, 1'b0, o[0]);
        scan(1'b0, 40, '1, o);
        check(o, {8'hff, ID});
        for (int i = 0; i < 7; i++) begin
            c = 4'(28'h8abef05 >> (4 * (6 - i)));
            scan(1'b1, 4, 40'(c), o);
            check(40'(o[3:0]), 40'h1);
            scan(1'b0, 40, '1, o);
            check(o, exp_dr(c, SC_OK));
        end
        trst_n <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        trst_n <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        tbit(1'b0, 1'b0, o[0]);
        scan(1'b0, 40, '1, o);
        check(o, {8'hff, ID});
        scan(1'b1, 4, 40'h5, o);
        repeat (5) tbit(1'b1, 1'b0, o[0]);
        tbit(1'b0, 1'b0, o[0]);
        scan(1'b0, 40, '1, o);
        check(o, {8'hff, ID});
        scan(1'b1, 4, 40'ha, o);
        repeat (6) scan(1'b0, 40, '1, o);
        check(o, exp_dr(4'ha, SC_WAIT));
        pop(37'h10_ffff_ffff, 1'b0);
        pop(37'h07_ffff_ffff, 1'b1);
        pop(37'h0f_ffff_ffff, 1'b1);
        repeat (5) pop(37'h07_ffff_ffff, 1'b1);
        check(40'(vld), 40'h0);
        $display("test scan view done");
        resetn_i <= 1'b0;
        smode <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        sw(8'ha5, 1'b0, '0, a, r);
        check(40'(a), 40'(SW_OK));
        check(40'(r), 40'({^ID, ID}));
        check(40'(dev_oe), 40'h0);
        sw(8'ha9, 1'b1, {^w, w}, a, r);
        check(40'(a), 40'(SW_OK));
        // the identity read posts a read request ahead of the write
        pop(37'h04_0000_0000, 1'b1);
        pop({5'b00001, w}, 1'b1);
        $display("test serial transfers done");
        sw(8'he5, 1'b0, '0, a, r);
        check(40'(a), 40'h7);
        sw(8'ha9, 1'b1, {~^w, w}, a, r);
        check(40'(lock), 40'h0);
        sw(8'ha9, 1'b1, {~^w, w}, a, r);
        check(40'(lock), 40'h1);
        sw(8'ha5, 1'b0, '0, a, r);
        check(40'(a), 40'h7);
        hold(50, 1'b1);
        hold(2, 1'b0);
        check(40'(lock), 40'h0);
        sw(8'ha5, 1'b0, '0, a, r);
        check(40'({a, r}), 40'({SW_OK, ^ID, ID}));
        $display("test serial lockout done");
        summarize();
    end
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
